// ===== fpm_defs.svh
// Purpose: Constants of the fetch pipeline and data memory map
// Assumes: Included by bare name from the phase, memory, core and assertion files
// Notes:   Definitions only
`ifndef FPM_DEFS_SVH
`define FPM_DEFS_SVH

// ----------------------------------------
// Program space
// ----------------------------------------
`define FPM_PC_W            13
`define FPM_IMPL_MASK       13'h07ff
`define FPM_RESET_VECTOR    13'h0000
`define FPM_INT_VECTOR      13'h0004
`define FPM_PC_INC          13'h0001

// ----------------------------------------
// Core registers, bank relative
// ----------------------------------------
`define FPM_ADDR_INDIRECT_ACCESS_PORT       7'h00
`define FPM_ADDR_PCL        7'h02
`define FPM_ADDR_STATUS     7'h03
`define FPM_ADDR_FSR        7'h04
`define FPM_ADDR_PC_HIGH_LATCH     7'h0a
`define FPM_ADDR_INTERRUPT_CONTROL     7'h0b

// ----------------------------------------
// Data memory, absolute addresses
// ----------------------------------------
`define FPM_ADDR_TIMER      8'h01
`define FPM_ADDR_PORT       8'h05
`define FPM_ADDR_INTCTL     8'h0b
`define FPM_ADDR_PIFLAGS    8'h0c
`define FPM_ADDR_CONVRES    8'h1e
`define FPM_ADDR_CONVA      8'h1f
`define FPM_ADDR_PRESCALE   8'h81
`define FPM_ADDR_PORTDIR    8'h85
`define FPM_ADDR_PIENABLE   8'h8c
`define FPM_ADDR_PWRSTAT    8'h8e
`define FPM_ADDR_OSCTRIM    8'h8f
`define FPM_ADDR_CONVB      8'h9f
`define FPM_GPR0_LO         8'h20
`define FPM_GPR0_HI         8'h7f
`define FPM_GPR1_LO         8'ha0
`define FPM_GPR1_HI         8'hef
`define FPM_COMMON_LO       8'hf0
`define FPM_BANK_MASK       8'h7f

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FPM_STATUS_BANK_BIT 5
`define FPM_STATUS_RESET    8'h18
`define FPM_STATUS_WMASK    8'he7
`define FPM_PC_HIGH_LATCH_RESET    5'h00
`define FPM_FSR_RESET       8'h00
`define FPM_PORT_RESET      8'hc0
`define FPM_DATA_RESET      8'h00
`define FPM_PHASE_Q1        4'h1
`define FPM_PHASE_Q2        4'h2
`define FPM_PHASE_Q3        4'h4
`define FPM_PHASE_Q4        4'h8

`endif

// ===== fpm_pkg.sv
// Purpose: Types shared by the fetch pipeline modules
// Assumes: Nothing
// Notes:   Constants live in fpm_defs.svh
package fpm_pkg;

    // ----------------------------------------
    // Quarter phase state
    // ----------------------------------------
    typedef enum logic [1:0] {
        FPM_Q1 = 2'b00,
        FPM_Q2 = 2'b01,
        FPM_Q3 = 2'b10,
        FPM_Q4 = 2'b11
    } fpm_phase_t;

    typedef logic [7:0] fpm_byte_t;

endpackage

// ===== fpm_dmem_if.sv
// Purpose: Data memory access channel between core and storage
// Assumes: Single clock, combinational read
// Notes:   Address is already bank resolved
interface fpm_dmem_if;
    logic [7:0] addr;
    logic [7:0] rd_data;
    logic       wr_en;
    logic [7:0] wr_data;

    modport core (output addr, output wr_en, output wr_data, input rd_data);
    modport mem  (input addr, input wr_en, input wr_data, output rd_data);
endinterface

// ===== fpm_phase_gen.sv
// Purpose: Divide the clock into four quarter phases
// Assumes: Synchronous active high reset
// Notes:   First phase after reset release is quarter_phase_one
`include "fpm_defs.svh"

module fpm_phase_gen
    import fpm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    output logic      [3:0] quarter_phase
);

    fpm_phase_t state;
    fpm_phase_t next_state;
    logic [3:0] next_quarter_phase;

    // ----------------------------------------
    // Phase sequencing
    // ----------------------------------------
    // Walk Q1..Q4 and decode a one-hot phase
    always_comb begin
        unique case (state)
            FPM_Q1: begin
                next_state         = FPM_Q2;
                next_quarter_phase = `FPM_PHASE_Q2;
            end
            FPM_Q2: begin
                next_state         = FPM_Q3;
                next_quarter_phase = `FPM_PHASE_Q3;
            end
            FPM_Q3: begin
                next_state         = FPM_Q4;
                next_quarter_phase = `FPM_PHASE_Q4;
            end
            FPM_Q4: begin
                next_state         = FPM_Q1;
                next_quarter_phase = `FPM_PHASE_Q1;
            end
        endcase
    end

    // Register phase state
    always_ff @(posedge clk) begin
        if (reset) begin
            state         <= FPM_Q1;
            quarter_phase <= `FPM_PHASE_Q1;
        end else begin
            state         <= next_state;
            quarter_phase <= next_quarter_phase;
        end
    end

endmodule

// ===== fpm_data_mem.sv
// Purpose: Banked data memory storage
// Assumes: Addresses arrive resolved, mirrors and common RAM folded
// Notes:   Unimplemented locations read zero and ignore writes
`include "fpm_defs.svh"

module fpm_data_mem
    import fpm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] conversion_value,
    fpm_dmem_if.mem         dm
);

    fpm_byte_t mem      [256];
    fpm_byte_t next_mem [256];

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // True where a physical byte exists
    function automatic logic fpm_implemented(input logic [7:0] a);
        logic gpr;
        logic sfr;
        gpr = (a >= `FPM_GPR0_LO && a <= `FPM_GPR0_HI) || (a >= `FPM_GPR1_LO && a <= `FPM_GPR1_HI);
        sfr = (a == `FPM_ADDR_TIMER) || (a == `FPM_ADDR_PORT) || (a == `FPM_ADDR_INTCTL)
           || (a == `FPM_ADDR_PIFLAGS) || (a == `FPM_ADDR_CONVA) || (a == `FPM_ADDR_PRESCALE)
           || (a == `FPM_ADDR_PORTDIR) || (a == `FPM_ADDR_PIENABLE) || (a == `FPM_ADDR_PWRSTAT)
           || (a == `FPM_ADDR_OSCTRIM) || (a == `FPM_ADDR_CONVB);
        return gpr || sfr;
    endfunction

    // Read port, conversion result is read only
    always_comb begin
        if (dm.addr == `FPM_ADDR_CONVRES) begin
            dm.rd_data = conversion_value;
        end else if (fpm_implemented(dm.addr)) begin
            dm.rd_data = mem[dm.addr];
        end else begin
            dm.rd_data = 8'h00;
        end
    end

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // Write only where storage exists
    always_comb begin
        next_mem = mem;
        if (dm.wr_en && fpm_implemented(dm.addr)) begin
            next_mem[dm.addr] = dm.wr_data;
        end
    end

    // Register storage
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= `FPM_DATA_RESET;
            end
            mem[`FPM_ADDR_PORT] <= `FPM_PORT_RESET;
        end else begin
            mem <= next_mem;
        end
    end

endmodule

// ===== fpm_core.sv
// Purpose: Instruction fetch pipeline, program counter and data map
// Assumes: Execute unit drives its request inputs in Q2 and Q4
// Notes:   ALU, stack and peripheral behaviour live elsewhere
`include "fpm_defs.svh"

// How it works
// - The clock is divided by four into non-overlapping quarter phases.
// - One instruction cycle is exactly four quarter phases, one through four.
// - Fetch of the next word overlaps execution of the current one.
// - A program counter change costs two cycles; the prefetched word is discarded.
// - The program counter increments in quarter phase one of each fetch cycle.
// - Fetched word enters the instruction latch in phase one, executes after.
// - Operand read in phase two, destination write in phase four.
// - Program counter is 13 bits wide, covering 8K words of 14 bits.
// - Only the low 2K words exist; higher fetches wrap into them.
// - Reset fetches from address zero; interrupts vector to address four.
// - Status bit five selects the data bank for direct addressing.
// - Each bank spans 128 bytes, special registers low, RAM above.
// - Frequently used bank 0 specials also answer at bank 1 addresses.
// - Bank 1 F0h to FFh reach bank 0 70h to 7Fh.
// - Data reached directly from the instruction or through the indirect pointer.
module fpm_core
    import fpm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [13:0] prog_data,
    input  wire logic  [6:0] exec_file_addr,
    input  wire logic        exec_read,
    input  wire logic        exec_write,
    input  wire logic  [7:0] exec_wdata,
    input  wire logic        exec_branch,
    input  wire logic [12:0] exec_target,
    input  wire logic        int_request,
    input  wire logic  [7:0] conversion_value,
    output logic      [12:0] prog_addr,
    output logic      [13:0] instruction_latch,
    output logic             instr_valid,
    output logic       [3:0] quarter_phase,
    output logic       [7:0] operand_data,
    output logic             bank_select_bit
);

    fpm_dmem_if dm ();

    logic [12:0] program_counter;
    logic [12:0] next_program_counter;
    logic [12:0] next_prog_addr;
    logic [13:0] fetch_buf;
    logic [13:0] next_fetch_buf;
    logic        buf_valid;
    logic        next_buf_valid;
    logic [13:0] next_instruction_latch;
    logic        next_instr_valid;
    logic  [7:0] next_operand_data;
    logic  [7:0] core_status;
    logic  [7:0] next_core_status;
    logic  [7:0] indirect_pointer;
    logic  [7:0] next_indirect_pointer;
    logic  [4:0] pc_high_latch;
    logic  [4:0] next_pc_high_latch;
    logic        next_bank_select_bit;
    logic        ph_q1;
    logic        ph_q2;
    logic        ph_q4;
    logic  [7:0] eff_addr;
    logic        core_hit;
    logic  [7:0] core_rdata;
    logic  [7:0] rd_value;
    logic        do_write;
    logic        pcl_write;
    logic        redirect;

    // ----------------------------------------
    // Leaf modules
    // ----------------------------------------
    // Quarter phase divider
    fpm_phase_gen u_phase (
        .clk           (clk),
        .reset         (reset),
        .quarter_phase (quarter_phase)
    );

    // Banked storage
    fpm_data_mem u_mem (
        .clk              (clk),
        .reset            (reset),
        .conversion_value (conversion_value),
        .dm               (dm.mem)
    );

    // ----------------------------------------
    // Address helpers
    // ----------------------------------------
    // Bank 0 registers visible from both banks
    function automatic logic fpm_is_mirror(input logic [6:0] a);
        return (a == `FPM_ADDR_INDIRECT_ACCESS_PORT) || (a == `FPM_ADDR_PCL) || (a == `FPM_ADDR_STATUS)
            || (a == `FPM_ADDR_FSR) || (a == `FPM_ADDR_PC_HIGH_LATCH) || (a == `FPM_ADDR_INTERRUPT_CONTROL);
    endfunction

    // Direct or pointer address, then fold mirrors and common RAM
    function automatic logic [7:0] fpm_resolve(input logic [6:0] fa, input logic bank, input logic [7:0] ptr);
        logic [7:0] a;
        if (fa == `FPM_ADDR_INDIRECT_ACCESS_PORT) begin
            a = ptr;
        end else begin
            a = {bank, fa};
        end
        if (fpm_is_mirror(a[6:0])) begin
            a = a & `FPM_BANK_MASK;
        end else if (a >= `FPM_COMMON_LO) begin
            a = a & `FPM_BANK_MASK;
        end
        return a;
    endfunction

    // ----------------------------------------
    // Data access path
    // ----------------------------------------
    // Phase decode
    assign ph_q1 = quarter_phase == `FPM_PHASE_Q1;
    assign ph_q2 = quarter_phase == `FPM_PHASE_Q2;
    assign ph_q4 = quarter_phase == `FPM_PHASE_Q4;

    // Resolve the operand address
    always_comb begin
        eff_addr = fpm_resolve(exec_file_addr, core_status[`FPM_STATUS_BANK_BIT],
                               indirect_pointer);
        core_hit = 1'b1;
        unique case (eff_addr)
            {1'b0, `FPM_ADDR_PCL}:    core_rdata = program_counter[7:0];
            {1'b0, `FPM_ADDR_STATUS}: core_rdata = core_status;
            {1'b0, `FPM_ADDR_FSR}:    core_rdata = indirect_pointer;
            {1'b0, `FPM_ADDR_PC_HIGH_LATCH}: core_rdata = {3'h0, pc_high_latch};
            default: begin
                core_hit   = 1'b0;
                core_rdata = 8'h00;
            end
        endcase
    end

    // Storage requests and the read mux
    always_comb begin
        do_write      = ph_q4 && instr_valid && exec_write;
        dm.addr       = eff_addr;
        dm.wr_en      = do_write && !core_hit;
        dm.wr_data    = exec_wdata;
        rd_value      = core_hit ? core_rdata : dm.rd_data;
        pcl_write     = do_write && (eff_addr == {1'b0, `FPM_ADDR_PCL});
    end

    // ----------------------------------------
    // Pipeline and core registers
    // ----------------------------------------
    // Next state of fetch, latch, counter and core registers
    always_comb begin
        next_program_counter   = program_counter;
        next_prog_addr         = prog_addr;
        next_fetch_buf         = fetch_buf;
        next_buf_valid         = buf_valid;
        next_instruction_latch = instruction_latch;
        next_instr_valid       = instr_valid;
        next_operand_data      = operand_data;
        next_core_status       = core_status;
        next_indirect_pointer  = indirect_pointer;
        next_pc_high_latch     = pc_high_latch;
        redirect               = 1'b0;
        // Fetch cycle opens: drive address, step counter
        if (ph_q1) begin
            next_prog_addr         = program_counter & `FPM_IMPL_MASK;
            next_program_counter   = program_counter + `FPM_PC_INC;
            next_instruction_latch = fetch_buf;
            next_instr_valid       = buf_valid;
        end
        // Operand read
        if (ph_q2 && instr_valid && exec_read) begin
            next_operand_data = rd_value;
        end
        // Destination write, fetch capture, program counter change
        if (ph_q4) begin
            next_fetch_buf = prog_data;
            if (do_write) begin
                unique case (eff_addr)
                    {1'b0, `FPM_ADDR_STATUS}: next_core_status =
                        (core_status & ~`FPM_STATUS_WMASK) | (exec_wdata & `FPM_STATUS_WMASK);
                    {1'b0, `FPM_ADDR_FSR}:    next_indirect_pointer = exec_wdata;
                    {1'b0, `FPM_ADDR_PC_HIGH_LATCH}: next_pc_high_latch = exec_wdata[4:0];
                    default: begin
                    end
                endcase
            end
            if (int_request) begin
                next_program_counter = `FPM_INT_VECTOR;
                redirect             = 1'b1;
            end else if (instr_valid && exec_branch) begin
                next_program_counter = exec_target;
                redirect             = 1'b1;
            end else if (pcl_write) begin
                next_program_counter = {pc_high_latch, exec_wdata};
                redirect             = 1'b1;
            end
            // Discard the prefetched word on any redirect
            next_buf_valid = !redirect;
        end
        next_bank_select_bit = next_core_status[`FPM_STATUS_BANK_BIT];
    end

    // Register pipeline and core state
    always_ff @(posedge clk) begin
        if (reset) begin
            program_counter   <= `FPM_RESET_VECTOR;
            prog_addr         <= `FPM_RESET_VECTOR;
            fetch_buf         <= 14'h0000;
            buf_valid         <= 1'b0;
            instruction_latch <= 14'h0000;
            instr_valid       <= 1'b0;
            operand_data      <= 8'h00;
            core_status       <= `FPM_STATUS_RESET;
            indirect_pointer  <= `FPM_FSR_RESET;
            pc_high_latch     <= `FPM_PC_HIGH_LATCH_RESET;
            bank_select_bit   <= 1'b0;
        end else begin
            program_counter   <= next_program_counter;
            prog_addr         <= next_prog_addr;
            fetch_buf         <= next_fetch_buf;
            buf_valid         <= next_buf_valid;
            instruction_latch <= next_instruction_latch;
            instr_valid       <= next_instr_valid;
            operand_data      <= next_operand_data;
            core_status       <= next_core_status;
            indirect_pointer  <= next_indirect_pointer;
            pc_high_latch     <= next_pc_high_latch;
            bank_select_bit   <= next_bank_select_bit;
        end
    end

endmodule

// ===== fpm_core_asserts.sv
// Purpose: Concurrent checks on the fetch pipeline top ports
// Assumes: One clock, synchronous active high reset
// Notes:   Attached by bind after the module
`include "fpm_defs.svh"

module fpm_core_asserts
    import fpm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [13:0] prog_data,
    input  wire logic  [6:0] exec_file_addr,
    input  wire logic        exec_read,
    input  wire logic        exec_write,
    input  wire logic  [7:0] exec_wdata,
    input  wire logic        exec_branch,
    input  wire logic [12:0] exec_target,
    input  wire logic        int_request,
    input  wire logic  [7:0] conversion_value,
    input  wire logic [12:0] prog_addr,
    input  wire logic [13:0] instruction_latch,
    input  wire logic        instr_valid,
    input  wire logic  [3:0] quarter_phase,
    input  wire logic  [7:0] operand_data,
    input  wire logic        bank_select_bit
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic fetch_seen;
    logic next_fetch_seen;
    logic redirect;

    // Program counter is live after the first fetch
    always_comb begin
        next_fetch_seen = fetch_seen | (quarter_phase == 4'h1);
    end
    always_ff @(posedge clk) begin
        fetch_seen <= reset ? 1'b0 : next_fetch_seen;
    end
    // Interrupt, branch or direct PCL write, each replacing the next fetch address
    assign redirect = int_request | (instr_valid & (exec_branch | (exec_write & (exec_file_addr == 7'h02))));

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_cycle_rest;
        quarter_phase == 4'h2 ##1 quarter_phase == 4'h4 ##1 quarter_phase == 4'h8 ##1 quarter_phase == 4'h1;
    endsequence
    sequence s_q4_q1(c);
        quarter_phase == 4'h8 && c ##1 quarter_phase == 4'h1;
    endsequence

    property p_phase_onehot;
        $onehot(quarter_phase);
    endproperty
    a_phase_onehot: assert property (p_phase_onehot) else $error("phase not one-hot");
    property p_phase_order;
        quarter_phase == 4'h1 |=> s_cycle_rest;
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase order broken");
    property p_addr_hold;
        quarter_phase != 4'h1 |=> $stable(prog_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved outside Q1");
    property p_pc_step;
        s_q4_q1(fetch_seen && !redirect) |=> prog_addr == (($past(prog_addr) + `FPM_PC_INC) & `FPM_IMPL_MASK);
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("fetch address did not step");
    property p_branch;
        s_q4_q1(instr_valid && exec_branch && !int_request)
            |=> !instr_valid && prog_addr == ($past(exec_target, 2) & `FPM_IMPL_MASK);
    endproperty
    a_branch: assert property (p_branch) else $error("branch target or flush wrong");
    property p_int_vector;
        s_q4_q1(int_request) |=> !instr_valid && prog_addr == `FPM_INT_VECTOR;
    endproperty
    a_int_vector: assert property (p_int_vector) else $error("interrupt vector wrong");
    property p_latch_hold;
        quarter_phase != 4'h1 |=> $stable(instruction_latch) && $stable(instr_valid);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch moved outside Q1");
    property p_capture;
        s_q4_q1(1'b1) |=> !instr_valid || instruction_latch == $past(prog_data, 2);
    endproperty
    a_capture: assert property (p_capture) else $error("latched word differs from fetch");
    property p_operand_hold;
        !(quarter_phase == 4'h2 && instr_valid && exec_read) |=> $stable(operand_data);
    endproperty
    a_operand_hold: assert property (p_operand_hold) else $error("operand moved without Q2 read");
    property p_bank_write;
        $changed(bank_select_bit) |-> $past(quarter_phase) == 4'h8 && $past(exec_write) && $past(instr_valid);
    endproperty
    a_bank_write: assert property (p_bank_write) else $error("bank bit moved without Q4 write");
endmodule

bind fpm_core fpm_core_asserts u_chk (.clk, .reset, .prog_data, .exec_file_addr, .exec_read, .exec_write,
    .exec_wdata, .exec_branch, .exec_target, .int_request, .conversion_value, .prog_addr, .instruction_latch,
    .instr_valid, .quarter_phase, .operand_data, .bank_select_bit);

// ===== fpm_prog_mem.sv
// Purpose: Program memory partner, one word per fetch address
// Assumes: Combinational read
// Notes:   Content is a fixed pattern of the address
module fpm_prog_mem
    import fpm_pkg::*;
(
    input  wire logic [12:0] prog_addr,
    output logic      [13:0] prog_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Low 2K words of 14 bits exist
    always_comb begin
        prog_data = {3'h0, prog_addr[10:0]} ^ 14'h2a5a;
    end
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the fetch pipeline core
// Assumes: Bench acts as execute unit, drives at falling edge
// Notes:   Each scenario syncs to quarter phases
module tb
    import fpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [13:0] prog_data;
    logic  [6:0] exec_file_addr = 7'h00;
    logic        exec_read = 1'b0;
    logic        exec_write = 1'b0;
    fpm_byte_t   exec_wdata = 8'h00;
    logic        exec_branch = 1'b0;
    logic [12:0] exec_target = 13'h0000;
    logic        int_request = 1'b0;
    fpm_byte_t   conversion_value = 8'hc3;
    logic [12:0] prog_addr;
    logic [13:0] instruction_latch;
    logic        instr_valid;
    logic  [3:0] quarter_phase;
    fpm_byte_t   operand_data;
    logic        bank_select_bit;
    int          mismatches = 0;
    int          compares = 0;

    always #4 clk = ~clk;

    fpm_core u_dut (.clk, .reset, .prog_data, .exec_file_addr, .exec_read, .exec_write, .exec_wdata,
        .exec_branch, .exec_target, .int_request, .conversion_value, .prog_addr, .instruction_latch,
        .instr_valid, .quarter_phase, .operand_data, .bank_select_bit);
    fpm_prog_mem u_pmem (.prog_addr, .prog_data);

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [13:0] pw(input logic [12:0] a);
        return {3'h0, a[10:0]} ^ 14'h2a5a;
    endfunction
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Bounded wait for a phase, optionally with a live instruction
    task automatic wait_q(input logic [3:0] p, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n > 16) begin
                mismatches++;
                tally_and_finish();
            end
        end while (!(quarter_phase === p && (instr_valid === 1'b1 || !v)));
    endtask
    // One instruction: levels from Q2 until the next Q1
    task automatic op(input logic [6:0] a, input logic r, input logic w, input fpm_byte_t d,
                      input logic b, input logic [12:0] t, input logic i);
        wait_q(4'h2, 1'b1);
        exec_file_addr = a;
        exec_read = r;
        exec_write = w;
        exec_wdata = d;
        exec_branch = b;
        exec_target = t;
        int_request = i;
        wait_q(4'h1, 1'b0);
        exec_read = 1'b0;
        exec_write = 1'b0;
        exec_branch = 1'b0;
        int_request = 1'b0;
    endtask
    task automatic wr(input logic [6:0] a, input fpm_byte_t d);
        op(a, 1'b0, 1'b1, d, 1'b0, 13'h0000, 1'b0);
    endtask
    task automatic rd(input logic [6:0] a);
        op(a, 1'b1, 1'b0, 8'h00, 1'b0, 13'h0000, 1'b0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Start of fetch after reset and phase order
    task automatic t_reset();
        check("phase", quarter_phase, 4'h1);
        check("addr", prog_addr, 13'h0000);
        check("valid", instr_valid, 1'b0);
        wait_q(4'h2, 1'b1);
        check("latch0", instruction_latch, pw(13'h0000));
        check("addr1", prog_addr, 13'h0001);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            check("phase", quarter_phase, 4'h1 << ((i + 2) % 4));
        end
        check("addr2", prog_addr, 13'h0002);
        check("latch1", instruction_latch, pw(13'h0001));
    endtask
    // Banks, mirrors, common RAM, indirect and holes
    task automatic t_data();
        wr(7'h20, 8'h5a);
        rd(7'h20);
        check("gpr0", operand_data, 8'h5a);
        wr(7'h03, 8'h20);
        rd(7'h03);
        check("status", operand_data, 8'h38);
        check("bank", bank_select_bit, 1'b1);
        rd(7'h20);
        check("gpr1", operand_data, 8'h00);
        wr(7'h20, 8'ha5);
        wr(7'h70, 8'h3c);
        wr(7'h04, 8'h21);
        wr(7'h03, 8'h00);
        check("bank", bank_select_bit, 1'b0);
        rd(7'h70);
        check("common", operand_data, 8'h3c);
        rd(7'h04);
        check("mirror", operand_data, 8'h21);
        wr(7'h00, 8'h77);
        rd(7'h21);
        check("indir", operand_data, 8'h77);
        rd(7'h00);
        check("indir_rd", operand_data, 8'h77);
        rd(7'h20);
        check("gpr0", operand_data, 8'h5a);
        wr(7'h06, 8'hff);
        rd(7'h06);
        check("hole", operand_data, 8'h00);
        rd(7'h1e);
        check("conv", operand_data, 8'hc3);
    endtask
    // Branch flush, wrap, interrupt priority, PC_LOW_BYTE write
    task automatic t_branch();
        op(7'h00, 1'b0, 1'b0, 8'h00, 1'b1, 13'h1234, 1'b0);
        wait_q(4'h2, 1'b0);
        check("wrap", prog_addr, 13'h0234);
        check("flush", instr_valid, 1'b0);
        wait_q(4'h2, 1'b1);
        check("target", instruction_latch, pw(13'h0234));
        op(7'h00, 1'b0, 1'b0, 8'h00, 1'b1, 13'h0100, 1'b1);
        wait_q(4'h2, 1'b0);
        check("vector", prog_addr, 13'h0004);
        check("flush", instr_valid, 1'b0);
        wr(7'h0a, 8'h05);
        wr(7'h02, 8'h10);
        wait_q(4'h2, 1'b0);
        check("pcl", prog_addr, 13'h0510);
        rd(7'h02);
        check("pcl_rd", operand_data, 8'h12);
    endtask
    // Reset in mid-run restarts at address zero
    task automatic t_rereset();
        wait_q(4'h4, 1'b0);
        reset = 1'b1;
        @(negedge clk);
        check("phase", quarter_phase, 4'h1);
        check("addr", prog_addr, 13'h0000);
        check("valid", instr_valid, 1'b0);
        reset = 1'b0;
        wait_q(4'h2, 1'b1);
        check("latch0", instruction_latch, pw(13'h0000));
    endtask

    initial begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_data();
        t_branch();
        t_rereset();
        tally_and_finish();
    end
endmodule
